// File: hw/asoi_regs.svh
`ifndef ASOI_REGS_SVH
`define ASOI_REGS_SVH
// ******************************
// Register map
// ******************************
`define ASOI_CTRL_ADDR 8'h00
`define ASOI_STAT_ADDR 8'h04
`define ASOI_IRQ_ADDR 8'h08
`define ASOI_MASK_ADDR 8'h0C
`define ASOI_SAMPLE_ADDR 8'h10
`define ASOI_ADDR_W 8
// ******************************
// Field positions, the control reset value and the IRQ width
// ******************************
`define ASOI_CTRL_OEN 0
`define ASOI_CTRL_PDN 1
`define ASOI_CTRL_RST 32'h0000_0001
`define ASOI_IRQ_OVR 0
`define ASOI_IRQ_LOCK 1
`define ASOI_IRQ_WAKE 2
`define ASOI_IRQ_W 3
// ******************************
// Codes and counts
// ******************************
`define ASOI_MID_CODE 10'h200
`define ASOI_MAX_CODE 10'h3FF
`define ASOI_MIN_CODE 10'h000
`define ASOI_RELOCK_CYC 100
`define ASOI_WAKE_CYC 100
`define ASOI_IDLE_CYC 16
`endif

// File: hw/asoi_pkg.sv
package asoi_pkg;
	// Four strap levels, lowest first
	typedef enum logic [1:0] {
		STRAP_GND,
		STRAP_THIRD,
		STRAP_TWO_THIRD,
		STRAP_VDD
	} asoi_strap_type;
	// Converter core result before formatting
	typedef struct packed {
		logic over;
		logic under;
		logic [9:0] code;
	} asoi_raw_type;
	// Formatted output bundle
	typedef struct packed {
		logic rangeExceededFlag;
		logic [9:0] sampleWord;
	} asoi_out_type;
endpackage

// File: hw/asoi_core.sv
// Local design decisions: the AHB-Lite register port and the address map.
`include "asoi_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module asoi_core #(
	parameter int LATENCY = 5,
	parameter int RELOCK_CYC = `ASOI_RELOCK_CYC,
	parameter int WAKE_CYC = `ASOI_WAKE_CYC,
	parameter int IDLE_CYC = `ASOI_IDLE_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clkEn,
	// Sampling clock from the capture side, asynchronous pin
	input wire logic sampleClkPin,
	input wire asoi_pkg::asoi_strap_type modeStrap,
	input wire asoi_pkg::asoi_raw_type rawIn,
	input wire logic outEnablePin_n,
	input wire logic powerDownSelectPin,
	// Parallel sample outputs, a value and an enable each, then status outputs with no enable
	output logic [9:0] sampleWordOut,
	output logic [9:0] sampleWordOe,
	output logic rangeExceededFlagOut,
	output logic rangeExceededFlagOe,
	output logic sampleValid,
	output logic stabilizerOn,
	output logic offsetBinary,
	output logic irq,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	import asoi_pkg::*;

	initial begin
		if (LATENCY < 1 || RELOCK_CYC < 1 || WAKE_CYC < 1 || IDLE_CYC < 2 ||
			RELOCK_CYC > 255 || WAKE_CYC > 255 || IDLE_CYC > 65535)
			$error("asoi_core: unsupported parameter value");
	end

	// ******************************
	// Pin synchronisers
	// ******************************
	// Three stages; a change counts when stage two and three agree
	logic [2:0] clkSync_q;
	logic [2:0] oeSync_q;
	logic [2:0] pdSync_q;
	logic sClk_q, oeN_q, pd_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			clkSync_q <= 3'h0;
			oeSync_q <= 3'h7;
			pdSync_q <= 3'h0;
		end else if (clkEn) begin
			clkSync_q <= {clkSync_q[1:0], sampleClkPin};
			oeSync_q <= {oeSync_q[1:0], outEnablePin_n};
			pdSync_q <= {pdSync_q[1:0], powerDownSelectPin};
		end
	end
	// Filtered levels only move once stages two and three agree
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sClk_q <= 1'b0;
			oeN_q <= 1'b1;
			pd_q <= 1'b0;
		end else if (clkEn) begin
			if (clkSync_q[2] == clkSync_q[1])
				sClk_q <= clkSync_q[2];
			if (oeSync_q[2] == oeSync_q[1])
				oeN_q <= oeSync_q[2];
			if (pdSync_q[2] == pdSync_q[1])
				pd_q <= pdSync_q[2];
		end
	end

	// ******************************
	// Strap decode
	// ******************************
	// Strap captured after reset release, not inside the reset
	asoi_strap_type strap_q;
	logic strapTaken_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			strap_q <= STRAP_GND;
			strapTaken_q <= 1'b0;
		end else if (clkEn && !strapTaken_q) begin
			strap_q <= modeStrap;
			strapTaken_q <= 1'b1;
		end
	end
	wire logic fmtOffset = strap_q == STRAP_GND ||
		strap_q == STRAP_THIRD;
	wire logic dcsOn = strap_q == STRAP_THIRD ||
		strap_q == STRAP_TWO_THIRD;
	assign offsetBinary = fmtOffset;
	assign stabilizerOn = dcsOn;

	// ******************************
	// Clock edges and sampling
	// ******************************
	logic sClkPrev_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			sClkPrev_q <= 1'b0;
		else if (clkEn)
			sClkPrev_q <= sClk_q;
	end
	// Hold happens on the rise; the fall only reopens tracking
	wire logic riseEdge = sClk_q && !sClkPrev_q;
	wire logic tracking = !sClk_q;

	// Stall watch: long gap without a rise drops the lock
	logic [15:0] idleCnt_q;
	logic [7:0] lockCnt_q;
	wire logic stalled = idleCnt_q >= 16'(IDLE_CYC);
	wire logic locked = lockCnt_q >= 8'(RELOCK_CYC);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			idleCnt_q <= 16'h0000;
		else if (clkEn)
			idleCnt_q <= riseEdge ? 16'h0000 :
				(stalled ? idleCnt_q : idleCnt_q + 16'h0001);
	end
	// Relock counts sampling rises, not fabric cycles
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			lockCnt_q <= 8'h00;
		else if (clkEn) begin
			if (stalled)
				lockCnt_q <= 8'h00;
			else if (riseEdge && !locked)
				lockCnt_q <= lockCnt_q + 8'h01;
		end
	end
	wire logic dcsReady = !dcsOn || locked;

	// ******************************
	// Nap handling
	// ******************************
	wire logic napReq = pd_q && !oeN_q;
	wire logic sleepReq = pd_q && oeN_q;
	logic [7:0] wakeCnt_q;
	wire logic awake = wakeCnt_q >= 8'(WAKE_CYC);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			wakeCnt_q <= 8'(WAKE_CYC);
		else if (clkEn) begin
			if (pd_q)
				wakeCnt_q <= 8'h00;
			else if (riseEdge && !awake)
				wakeCnt_q <= wakeCnt_q + 8'h01;
		end
	end

	// ******************************
	// Format and pipeline
	// ******************************
	// Saturate on either overrange, flag raised
	asoi_out_type fmtWord;
	always_comb begin
		logic [9:0] c;
		c = rawIn.over ? `ASOI_MAX_CODE :
			(rawIn.under ? `ASOI_MIN_CODE : rawIn.code);
		fmtWord.sampleWord = fmtOffset ? c :
			{~c[9], c[8:0]};
		fmtWord.rangeExceededFlag = rawIn.over | rawIn.under;
	end

	// Word and flag travel as one struct through the pipe
	asoi_out_type pipe_q [LATENCY];
	logic [LATENCY-1:0] vld_q;
	genvar g;
	generate
		for (g = 0; g < LATENCY; g++) begin : gStage
			// Stage input: the formatter for the first, else the stage before
			asoi_out_type stIn;
			logic stVld;
			if (g == 0) begin : gFirst
				assign stIn = fmtWord;
				assign stVld = dcsReady && awake;
			end else begin : gNext
				assign stIn = pipe_q[g-1];
				assign stVld = vld_q[g-1];
			end
			// A stall or power down voids every word still in flight
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					pipe_q[g] <= '0;
					vld_q[g] <= 1'b0;
				end else if (clkEn && (stalled || pd_q)) begin
					vld_q[g] <= 1'b0;
				end else if (clkEn && riseEdge) begin
					pipe_q[g] <= stIn;
					vld_q[g] <= stVld;
				end
			end
		end
	endgenerate

	// ******************************
	// Register file
	// ******************************
	logic [31:0] ctrl_q;
	logic [`ASOI_IRQ_W-1:0] irqStat_q, irqMask_q;
	logic wrPend_q;
	logic [`ASOI_ADDR_W-1:0] wrAddr_q;
	logic [31:0] rdData_q;
	wire logic acc = hsel && hready && htrans[1];
	wire logic [`ASOI_ADDR_W-1:0] aOff = haddr[`ASOI_ADDR_W-1:0];
	wire logic wrCtrl = wrPend_q && wrAddr_q == `ASOI_CTRL_ADDR;
	wire logic wrIrq = wrPend_q && wrAddr_q == `ASOI_IRQ_ADDR;
	wire logic wrMask = wrPend_q && wrAddr_q == `ASOI_MASK_ADDR;
	// Software can force the outputs off through OEN or PDN, on top of the pins
	wire logic swOff = !ctrl_q[`ASOI_CTRL_OEN];
	wire logic swNap = ctrl_q[`ASOI_CTRL_PDN];
	wire logic outDisable = oeN_q || napReq || sleepReq ||
		swOff || swNap;

	// Events for sticky status
	logic lockedPrev_q, awakePrev_q;
	wire logic [`ASOI_IRQ_W-1:0] evt = {
		awake && !awakePrev_q,
		dcsOn && locked && !lockedPrev_q,
		riseEdge && fmtWord.rangeExceededFlag};
	wire logic [31:0] statWord = {26'h0, locked, awake, napReq, dcsOn,
		fmtOffset, outDisable};
	wire logic [31:0] rdMux =
		(aOff == `ASOI_CTRL_ADDR) ? ctrl_q :
		(aOff == `ASOI_STAT_ADDR) ? statWord :
		(aOff == `ASOI_IRQ_ADDR) ? {29'h0, irqStat_q} :
		(aOff == `ASOI_MASK_ADDR) ? {29'h0, irqMask_q} :
		(aOff == `ASOI_SAMPLE_ADDR) ? {21'h0, pipe_q[LATENCY-1]} :
		32'h0000_0000;

	// Address phase latch; data returns in the next cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= '0;
			rdData_q <= 32'h0000_0000;
		end else if (clkEn) begin
			wrPend_q <= acc && hwrite;
			wrAddr_q <= aOff;
			if (acc && !hwrite)
				rdData_q <= rdMux;
		end
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `ASOI_CTRL_RST;
			irqMask_q <= '0;
		end else if (clkEn) begin
			if (wrCtrl)
				ctrl_q <= {30'h0, hwdata[1:0]};
			if (wrMask)
				irqMask_q <= hwdata[`ASOI_IRQ_W-1:0];
		end
	end
	// Set beats clear so an event in the clearing cycle survives
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irqStat_q <= '0;
			lockedPrev_q <= 1'b0;
			awakePrev_q <= 1'b1;
		end else if (clkEn) begin
			irqStat_q <= (irqStat_q &
				~(wrIrq ? hwdata[`ASOI_IRQ_W-1:0] : '0)) | evt;
			lockedPrev_q <= locked;
			awakePrev_q <= awake;
		end
	end
	assign irq = |(irqStat_q & irqMask_q);
	assign hrdata = rdData_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ******************************
	// Output drivers
	// ******************************
	logic [9:0] wordOut_q;
	logic flagOut_q, valid_q;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wordOut_q <= 10'h000;
			flagOut_q <= 1'b0;
			valid_q <= 1'b0;
		end else if (clkEn) begin
			wordOut_q <= pipe_q[LATENCY-1].sampleWord;
			flagOut_q <= pipe_q[LATENCY-1].rangeExceededFlag;
			valid_q <= vld_q[LATENCY-1] && !outDisable;
		end
	end
	assign sampleWordOut = wordOut_q;
	assign rangeExceededFlagOut = flagOut_q;
	assign sampleWordOe = {10{!outDisable}};
	assign rangeExceededFlagOe = !outDisable;
	assign sampleValid = valid_q;
	wire logic unusedBits = &{hsize, tracking, hwdata[31:2], haddr[31:8]};
endmodule
`default_nettype wire

// File: test/asoi_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module asoi_core_props (
	input wire logic clock,
	input wire logic nrst,
	input wire asoi_pkg::asoi_strap_type modeStrap,
	input wire logic outEnablePin_n,
	input wire logic powerDownSelectPin,
	input wire logic [9:0] sampleWordOut,
	input wire logic [9:0] sampleWordOe,
	input wire logic rangeExceededFlagOut,
	input wire logic rangeExceededFlagOe,
	input wire logic sampleValid,
	input wire logic stabilizerOn,
	input wire logic offsetBinary,
	input wire logic hreadyout,
	input wire logic hresp
);
	import asoi_pkg::*;
	// ****
	// Pin checks
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence outsOff;
		sampleWordOe == 10'h000 && !rangeExceededFlagOe;
	endsequence
	sequence overOn;
		sampleValid && rangeExceededFlagOut;
	endsequence
	// Five cycles leave room for the pin synchroniser
	a_oe_hiz: assert property (
		outEnablePin_n [*5] |-> outsOff) else $error("driven while disabled");
	a_nap_hiz: assert property (
		powerDownSelectPin [*5] |-> outsOff) else $error("driven in nap");
	a_oe_group: assert property (
		sampleWordOe == {10{rangeExceededFlagOe}}) else $error("split enables");
	a_fmt_strap: assert property (
		sampleValid |-> offsetBinary == (modeStrap inside {STRAP_GND, STRAP_THIRD}))
		else $error("wrong format");
	a_dcs_strap: assert property (
		sampleValid |-> stabilizerOn ==
		(modeStrap inside {STRAP_THIRD, STRAP_TWO_THIRD})) else $error("dcs");
	a_sat_offset: assert property (
		overOn ##0 offsetBinary |-> sampleWordOut inside {10'h3FF, 10'h000})
		else $error("offset word not saturated");
	a_sat_twos: assert property (
		overOn ##0 !offsetBinary |-> sampleWordOut inside {10'h1FF, 10'h200})
		else $error("twos word not saturated");
	// Word holds for six cycles after a valid update, never a ripple
	a_one_update: assert property (
		$changed(sampleWordOut) && sampleValid |=> $stable(sampleWordOut) [*6])
		else $error("word moved twice");
	a_bus_okay: assert property (
		hreadyout && !hresp) else $error("bus wait or error");
endmodule
bind asoi_core asoi_core_props i_props (.clock, .nrst, .modeStrap,
	.outEnablePin_n, .powerDownSelectPin, .sampleWordOut, .sampleWordOe,
	.rangeExceededFlagOut, .rangeExceededFlagOe, .sampleValid,
	.stabilizerOn, .offsetBinary, .hreadyout, .hresp);
`default_nettype wire

// File: test/asoi_capture.sv
`timescale 1ns/10ps
`default_nettype none
module asoi_capture (
	input wire logic clock,
	input wire logic run,
	input wire logic [9:0] wordPin,
	input wire logic [9:0] wordOe,
	input wire logic flagPin,
	input wire logic flagOe,
	input wire logic sampleValid,
	output logic sampleClkPin,
	output logic capStrobe,
	output asoi_pkg::asoi_out_type capWord
);
	import asoi_pkg::*;
	// ****
	// Capture side
	// ****
	logic [3:0] phase = 4'h0;
	logic [10:0] lvl;
	// Released lines show the inverse, so a stale value never matches
	assign lvl = {flagPin, wordPin} ^ ~{flagOe, wordOe};
	assign sampleClkPin = phase[3];
	// Sixteen cycles a sample; the clock stands still when run is low
	always @(posedge clock) begin
		if (run) phase <= phase + 4'h1;
		capStrobe <= run && phase == 4'h7 && sampleValid;
		capWord <= lvl;
	end
endmodule
`default_nettype wire

// File: test/tb.sv
`include "asoi_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
	import asoi_pkg::*;
	// ****
	// Bench
	// ****
	logic clock = 1'b0, nrst = 1'b0, run = 1'b0, oen = 1'b0, pdn = 1'b0;
	logic hwrite = 1'b0, hreadyout, hresp, irq, vld, stab, ob, flag, flagOe;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [9:0] word, wordOe;
	logic sClk, capStrobe;
	asoi_strap_type strap = STRAP_GND;
	asoi_raw_type raw = '0;
	asoi_out_type capWord;
	asoi_out_type notes[$];
	int n_fail = 0, num_checks = 0, seed = 32'h7c29;
	always #4 clock = ~clock;
	asoi_core #(.RELOCK_CYC(4), .WAKE_CYC(4)) i_asoi_core (.clock, .nrst,
		.clkEn(1'b1), .sampleClkPin(sClk), .modeStrap(strap), .rawIn(raw),
		.outEnablePin_n(oen), .powerDownSelectPin(pdn), .sampleWordOut(word),
		.sampleWordOe(wordOe), .rangeExceededFlagOut(flag),
		.rangeExceededFlagOe(flagOe), .sampleValid(vld), .stabilizerOn(stab),
		.offsetBinary(ob), .irq, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
	asoi_capture i_asoi_capture (.clock, .run, .wordPin(word), .wordOe,
		.flagPin(flag), .flagOe, .sampleValid(vld), .sampleClkPin(sClk),
		.capStrobe, .capWord);
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
	endtask
	// Address phase held until hready, then data phase until hready
	task automatic bus(logic wr, logic [31:0] a, d, output logic [31:0] r);
		@(posedge clock);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wait_valid();
		for (int k = 0; k < 900 && vld !== 1'b1; k++) @(posedge clock);
		check("valid", vld, 1'b1);
	endtask
	// Expected word from the strap the bench chose, not from the design
	task automatic sample(logic ov, un, logic [9:0] c);
		asoi_out_type e;
		raw <= '{ov, un, c};
		e.rangeExceededFlag = ov | un;
		e.sampleWord = ov ? 10'h3FF : un ? 10'h000 : c;
		if (strap inside {STRAP_TWO_THIRD, STRAP_VDD}) e.sampleWord[9] ^= 1'b1;
		cyc(200);
		notes.push_back(e);
		cyc(20);
	endtask
	always @(posedge clock)
		if (capStrobe && notes.size() > 0)
			check("capture", capWord, notes.pop_front());
	initial begin
		logic [31:0] r;
		run <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			strap <= asoi_strap_type'(s);
			nrst <= 1'b0;
			cyc(5);
			nrst <= 1'b1;
			wait_valid();
			check("format", ob, s < 2);
			check("stabilizer", stab, s == 1 || s == 2);
			sample(0, 0, 10'h200);
			sample(0, 0, 10'h3FF);
			sample(1, 0, 10'($random(seed)));
			sample(0, 1, 10'($random(seed)));
			sample(0, 0, 10'($random(seed)));
			if (s == 1 || s == 2) begin
				run <= 1'b0;
				cyc(100);
				run <= 1'b1;
				cyc(24);
				check("relock", vld, 1'b0);
				wait_valid();
			end
		end
		bus(0, `ASOI_CTRL_ADDR, 0, r);
		check("ctrl", r, `ASOI_CTRL_RST);
		bus(0, 32'h40, 0, r);
		check("unmapped", r, 0);
		// Mask bit high lets the status bit through to irq
		bus(1, `ASOI_MASK_ADDR, 32'h0, r);
		raw <= '{1'b1, 1'b0, 10'h155};
		cyc(200);
		bus(1, `ASOI_IRQ_ADDR, 32'h7, r);
		check("masked", irq, 1'b0);
		bus(1, `ASOI_MASK_ADDR, 32'h1, r);
		cyc(20);
		check("irq", irq, 1'b1);
		raw <= '0;
		cyc(200);
		bus(1, `ASOI_IRQ_ADDR, 32'h7, r);
		bus(0, `ASOI_IRQ_ADDR, 0, r);
		check("cleared", r[0], 1'b0);
		check("irq off", irq, 1'b0);
		// Output enable moved only while the clock stands idle
		run <= 1'b0;
		oen <= 1'b1;
		cyc(10);
		check("oe", {flagOe, wordOe}, 0);
		oen <= 1'b0;
		run <= 1'b1;
		pdn <= 1'b1;
		cyc(40);
		check("nap", {flagOe, wordOe}, 0);
		pdn <= 1'b0;
		cyc(8);
		check("wake", vld, 1'b0);
		wait_valid();
		check("left", notes.size(), 0);
		wrap_up();
	end
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end
endmodule
`default_nettype wire
